/* File: rtl/los_cfg_pkg.sv */
package los_cfg_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_MODE     = 8'h00;
  localparam logic [7:0] ADDR_PCD      = 8'h04;
  localparam logic [7:0] ADDR_PCR      = 8'h08;
  localparam logic [7:0] ADDR_OPT      = 8'h0c;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_CMD      = 8'h1c;
  localparam logic [7:0] ADDR_SCRATCH  = 8'h20;
  // mode register fields
  localparam int BIT_STD   = 0;
  localparam int BIT_JPN   = 1;
  localparam int BIT_TXC0  = 2;
  localparam int BIT_RXC0  = 4;
  // option register fields
  localparam int BIT_XIRQ  = 0;
  localparam int BIT_PDEN  = 1;
  // status fields
  localparam int BIT_LOS   = 0;
  localparam int BIT_T1    = 1;
  localparam int BIT_J1    = 2;
  localparam int BIT_E1    = 3;
  // irq fields: 0 los raise, 1 los clear, 2 recovery progress
  localparam int IRQ_W     = 3;
  localparam int IRQ_SET   = 0;
  localparam int IRQ_CLR   = 1;
  localparam int IRQ_XREC  = 2;
  localparam logic [7:0] RST_MODE = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [IRQ_W-1:0] RST_MASK = 3'h0;
  localparam int ZERO_PER_STEP = 16;
  localparam int DENS_RUN      = 15;
  localparam int CNT_W         = 13;
  typedef enum logic [1:0] {
    CODE_NRZ  = 2'b00,
    CODE_AMI  = 2'b01,
    CODE_AMI7 = 2'b10,
    CODE_B8ZS = 2'b11
  } line_code_t;
endpackage : los_cfg_pkg

/* File: rtl/los_detect.sv */
`timescale 1ns/1ns
module los_detect
  import los_cfg_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             bit_tick,
  input  wire logic             bit_one,
  input  wire logic [7:0]       det_count,
  input  wire logic [7:0]       rec_count,
  input  wire logic             dens_en,
  output logic                  los,
  output logic                  rec_pulse
);
  logic [CNT_W-1:0] zero_run;
  logic [CNT_W-1:0] win_cnt;
  logic [CNT_W-1:0] ones;
  logic [4:0]       dens_run;
  logic             dens_bad;
  logic [CNT_W-1:0] det_lim;
  logic [CNT_W-1:0] rec_lim;

  // count = (value+1)*16 for detect, value+1 ones for recovery
  assign det_lim = CNT_W'((det_count + 9'h001) * ZERO_PER_STEP);
  assign rec_lim = CNT_W'(rec_count + 9'h001);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_run <= '0;
    end else if (bit_tick) begin
      if (bit_one) zero_run <= '0;
      else if (zero_run != det_lim) zero_run <= zero_run + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt  <= '0;
      ones     <= '0;
      dens_run <= '0;
      dens_bad <= 1'b0;
    end else if (bit_tick && los) begin
      if (win_cnt + 1'b1 >= det_lim) begin
        win_cnt  <= '0;
        ones     <= '0;
        dens_bad <= 1'b0;
      end else begin
        win_cnt <= win_cnt + 1'b1;
        ones    <= ones + CNT_W'(bit_one);
        if (!bit_one && dens_run >= 5'(DENS_RUN - 1))
          dens_bad <= 1'b1;
      end
      // run length saturates so a long run never wraps past the limit
      if (bit_one) dens_run <= 5'h00;
      else if (dens_run != 5'(DENS_RUN)) dens_run <= dens_run + 5'h01;
    end else if (!los) begin
      win_cnt  <= '0;
      ones     <= '0;
      dens_run <= '0;
      dens_bad <= 1'b0;
    end
  end

  logic recover;
  assign recover = (ones + CNT_W'(bit_one) >= rec_lim)
                   && !(dens_en && dens_bad);
  assign rec_pulse = bit_tick && los && bit_one
                     && win_cnt == '0 && ones == '0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) los <= 1'b0;
    else if (bit_tick && !los && !bit_one && zero_run + 1'b1 == det_lim)
      los <= 1'b1;
    else if (bit_tick && los && recover)
      los <= 1'b0;
  end

  a_los_raise: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bit_tick && !los && !bit_one && zero_run + 1'b1 == det_lim)
    |=> los) else $error("los not raised");
  a_los_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (los && !bit_tick) |=> los) else $error("los dropped");
endmodule : los_detect

/* File: rtl/t1_init_los.sv */
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module t1_init_los
  import los_cfg_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        line_bit_tick,
  input  wire logic        line_bit_one,
  output logic             los,
  output logic             irq,
  output logic             is_j1,
  output logic             is_e1,
  output line_code_t       tx_code,
  output line_code_t       rx_code
);
  // ---------------------------------------------------------------
  // reset and input synchronisers
  // ---------------------------------------------------------------
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  logic tick_s1, tick_s2, tick_d, one_s1, one_s2;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_s1 <= 1'b0;
      tick_s2 <= 1'b0;
      tick_d  <= 1'b0;
      one_s1  <= 1'b0;
      one_s2  <= 1'b0;
    end else begin
      tick_s1 <= line_bit_tick;
      tick_s2 <= tick_s1;
      tick_d  <= tick_s2;
      one_s1  <= line_bit_one;
      one_s2  <= one_s1;
    end
  end
  logic bit_tick;
  assign bit_tick = tick_s2 && !tick_d;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]       mode_reg;
  logic [7:0]       los_detect_count;
  logic [7:0]       los_recover_count;
  logic [1:0]       opt_reg;
  logic [7:0]       scratch;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic             line_standard_select;
  logic             japan_variant_select;
  logic             extra_recovery_irq_en;
  logic             pulse_density_check_en;

  assign line_standard_select   = mode_reg[BIT_STD];
  assign japan_variant_select   = mode_reg[BIT_JPN];
  assign extra_recovery_irq_en  = opt_reg[BIT_XIRQ];
  assign pulse_density_check_en = opt_reg[BIT_PDEN];

  logic wr_req, rd_req;
  assign wr_req = avs_write && !avs_read;
  assign rd_req = avs_read && !avs_write;

  // two-cycle read: waitrequest low for a read after one wait
  logic rd_done;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rd_done <= 1'b0;
    else        rd_done <= rd_req && !rd_done;
  end
  assign avs_waitrequest = rd_req && !rd_done;

  // any write order is accepted, fields are independent
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg          <= RST_MODE;
      los_detect_count  <= RST_ZERO;
      los_recover_count <= RST_ZERO;
      opt_reg           <= 2'h0;
      scratch           <= RST_ZERO;
      irq_mask          <= RST_MASK;
    end else if (wr_req) begin
      case (avs_address)
        ADDR_MODE:     mode_reg          <= avs_writedata[7:0];
        ADDR_PCD:      los_detect_count  <= avs_writedata[7:0];
        ADDR_PCR:      los_recover_count <= avs_writedata[7:0];
        ADDR_OPT:      opt_reg           <= avs_writedata[1:0];
        ADDR_SCRATCH:  scratch           <= avs_writedata[7:0];
        ADDR_IRQ_MASK: irq_mask          <= avs_writedata[IRQ_W-1:0];
        default: ; // unused addresses take no state
      endcase
    end
  end

  // command register: write-only, clears the detector state
  logic soft_clr;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) soft_clr <= 1'b0;
    else soft_clr <= wr_req && avs_address == ADDR_CMD
                     && avs_writedata[0];
  end

  // ---------------------------------------------------------------
  // mode decode and line codes
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      is_j1   <= 1'b0;
      is_e1   <= 1'b0;
      tx_code <= CODE_NRZ;
      rx_code <= CODE_NRZ;
    end else begin
      is_e1   <= !line_standard_select;
      is_j1   <= line_standard_select && japan_variant_select;
      tx_code <= line_code_t'(mode_reg[BIT_TXC0+1:BIT_TXC0]);
      rx_code <= line_code_t'(mode_reg[BIT_RXC0+1:BIT_RXC0]);
    end
  end

  // ---------------------------------------------------------------
  // loss of signal
  // ---------------------------------------------------------------
  logic det_rst_n;
  logic rec_pulse;
  assign det_rst_n = rst_n && !soft_clr;
  los_detect u_los (
    .sys_clk   (sys_clk),
    .rst_n     (det_rst_n),
    .bit_tick  (bit_tick),
    .bit_one   (one_s2),
    .det_count (los_detect_count),
    .rec_count (los_recover_count),
    .dens_en   (pulse_density_check_en),
    .los       (los),
    .rec_pulse (rec_pulse)
  );

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  logic los_d;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) los_d <= 1'b0;
    else        los_d <= los;
  end

  logic [IRQ_W-1:0] ev;
  assign ev[IRQ_SET]  = los && !los_d;
  assign ev[IRQ_CLR]  = !los && los_d;
  assign ev[IRQ_XREC] = extra_recovery_irq_en && rec_pulse;

  logic [IRQ_W-1:0] w1c;
  assign w1c = (wr_req && avs_address == ADDR_IRQ_STAT)
               ? avs_writedata[IRQ_W-1:0] : '0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) irq_stat <= '0;
    else        irq_stat <= (irq_stat & ~w1c) | ev; // set wins
  end
  assign irq = |(irq_stat & irq_mask);

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) avs_readdata <= '0;
    else if (rd_req && !rd_done) begin
      case (avs_address)
        ADDR_MODE:     avs_readdata <= {24'h0, mode_reg};
        ADDR_PCD:      avs_readdata <= {24'h0, los_detect_count};
        ADDR_PCR:      avs_readdata <= {24'h0, los_recover_count};
        ADDR_OPT:      avs_readdata <= {30'h0, opt_reg};
        ADDR_SCRATCH:  avs_readdata <= {24'h0, scratch};
        ADDR_STATUS:   avs_readdata <= {28'h0, is_e1, is_j1,
                                        !is_e1 && !is_j1, los};
        ADDR_IRQ_STAT: avs_readdata <= {29'h0, irq_stat};
        ADDR_IRQ_MASK: avs_readdata <= {29'h0, irq_mask};
        default:       avs_readdata <= '0;
      endcase
    end
  end

  a_irq_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (los && !los_d) |=> irq_stat[IRQ_SET])
    else $error("los irq not set");
  a_mode_j1: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (line_standard_select && japan_variant_select) |=> is_j1)
    else $error("j1 not selected");
  a_mode_e1: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !line_standard_select |=> is_e1 && !is_j1)
    else $error("e1 not selected");
  a_xrec_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!extra_recovery_irq_en && !irq_stat[IRQ_XREC]) |=>
    !irq_stat[IRQ_XREC]) else $error("extra irq leak");
  a_code_track: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> tx_code == $past(mode_reg[BIT_TXC0+1:BIT_TXC0]))
    else $error("tx code stale");
  a_cmd_readzero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rd_req && !rd_done && avs_address == ADDR_CMD) |=> avs_readdata == 0)
    else $error("cmd reads back");

  // ---------------------------------------------------------------
  // bus and register checks
  // ---------------------------------------------------------------
  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      ADDR_MODE, ADDR_PCD, ADDR_PCR, ADDR_OPT, ADDR_STATUS,
      ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_CMD, ADDR_SCRATCH:
        addr_mapped = 1'b1;
      default:
        addr_mapped = 1'b0;
    endcase
  endfunction : addr_mapped

  // consecutive wait cycles seen by the master
  logic [1:0] wait_run;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_run <= 2'h0;
    end else if (!avs_waitrequest) begin
      wait_run <= 2'h0;
    end else if (wait_run != 2'h3) begin
      wait_run <= wait_run + 2'h1;
    end
  end

  sequence s_rd_first;
    rd_req && !rd_done;
  endsequence

  sequence s_rd_second;
    rd_req && !avs_waitrequest;
  endsequence

  a_rd_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_rd_first |-> avs_waitrequest)
    else $error("read without wait");

  a_rd_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_rd_first ##1 rd_req |-> s_rd_second)
    else $error("read not answered");

  a_wait_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wait_run <= 2'h1)
    else $error("wait too long");

  a_wr_nowait: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_req |-> !avs_waitrequest)
    else $error("write stalled");

  a_pcd_lands: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_req && avs_address == ADDR_PCD)
    |=> los_detect_count == $past(avs_writedata[7:0]))
    else $error("detect count lost");

  a_pcr_lands: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_req && avs_address == ADDR_PCR)
    |=> los_recover_count == $past(avs_writedata[7:0]))
    else $error("recover count lost");

  a_unused_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rd_req && !rd_done && !addr_mapped(avs_address))
    |=> avs_readdata == '0)
    else $error("unused reads nonzero");

  a_unused_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_req && !addr_mapped(avs_address))
    |=> $stable(mode_reg) && $stable(opt_reg) && $stable(scratch))
    else $error("unused write landed");

  a_mode_t1: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (line_standard_select && !japan_variant_select)
    |=> !is_j1 && !is_e1)
    else $error("t1 not selected");

  a_rx_track: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> rx_code == $past(mode_reg[BIT_RXC0+1:BIT_RXC0]))
    else $error("rx code stale");

  a_clr_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!los && los_d) |=> irq_stat[IRQ_CLR])
    else $error("clear irq not set");

  a_xrec_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (extra_recovery_irq_en && rec_pulse) |=> irq_stat[IRQ_XREC])
    else $error("extra irq not set");

  a_cmd_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    soft_clr |-> !los)
    else $error("cmd left los set");
endmodule : t1_init_los

/* File: dv/line_source.sv */
`timescale 1ns/1ns
// ----------------------------------------
// far line end: bit clock and received data
// ----------------------------------------
module line_source (
  input  wire logic sys_clk,
  output logic      line_bit_tick,
  output logic      line_bit_one
);
  int div = 8;
  initial begin
    line_bit_tick = 1'b0;
    line_bit_one  = 1'b0;
  end
  // data settles half a bit ahead of the tick, then flips once it falls
  task automatic send(input logic b);
    @(posedge sys_clk);
    line_bit_one <= b;
    repeat (div / 2) @(posedge sys_clk);
    line_bit_tick <= 1'b1;
    repeat (div / 2) @(posedge sys_clk);
    line_bit_tick <= 1'b0;
    line_bit_one  <= ~b;
  endtask : send
endmodule : line_source

/* File: dv/tb_t1_init_los.sv */
`timescale 1ns/1ns
module tb_t1_init_los
  import los_cfg_pkg::*;
;
  logic        sys_clk;
  logic        resetn;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        line_bit_tick;
  logic        line_bit_one;
  logic        los;
  logic        irq;
  logic        is_j1;
  logic        is_e1;
  line_code_t  tx_code;
  line_code_t  rx_code;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          zrun = 0;
  logic        los_m = 1'b0;
  logic [31:0] rng = 32'h2d;
  logic [31:0] q;
  logic [31:0] v;
  logic [31:0] exq[$];
  logic [7:0]  wa[6] = '{ADDR_MODE, ADDR_PCD, ADDR_PCR, ADDR_OPT,
                         ADDR_IRQ_MASK, ADDR_SCRATCH};
  logic [31:0] wm[6] = '{32'h3f, 32'hff, 32'hff, 32'h3, 32'h7, 32'hff};

  t1_init_los DUT (.sys_clk(sys_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .line_bit_tick(line_bit_tick),
    .line_bit_one(line_bit_one), .los(los), .irq(irq), .is_j1(is_j1),
    .is_e1(is_e1), .tx_code(tx_code), .rx_code(rx_code));
  line_source src (.sys_clk(sys_clk), .line_bit_tick(line_bit_tick),
    .line_bit_one(line_bit_one));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_mismatch++;
    print_verdict();
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    logic wt;
    n = 0;
    wt = 1'b1;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    // waitrequest and data are settled mid-cycle, ahead of the edge
    while (wt && n < 50) begin
      @(negedge sys_clk);
      wt = (avs_waitrequest !== 1'b0);
      q  = avs_readdata;
      n++;
      @(posedge sys_clk);
    end
    if (wt) n_mismatch++;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic line(input int k, input int per, input int nbits);
    logic b;
    for (int n = 0; n < nbits; n++) begin
      b = (n % per) < k;
      src.send(b);
      zrun = b ? 0 : zrun + 1;
      if (zrun >= 176) los_m = 1'b1;
    end
    repeat (6) @(posedge sys_clk);
  endtask : line
  task automatic print_verdict();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    resetn        = 1'b0;
    avs_address   = 8'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("is_e1", is_e1, 32'h0);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, wa[i], 32'h0);
      check("reset", q, (i == 0) ? RST_MODE : RST_ZERO);
    end
    for (int i = 0; i < 6; i++) begin
      v = xs() & wm[i];
      exq.push_back(v);
      bus(1'b1, wa[i], v);
    end
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, wa[i], 32'h0);
      check("readback", q, exq.pop_front());
    end
    bus(1'b1, 8'h40, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    check("unmapped", q, 32'h0);
    bus(1'b0, ADDR_CMD, 32'h0);
    check("cmd", q, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = {26'h0, 2'(3 - i), 2'(i), 1'(i & 1), 1'(i >> 1)};
      bus(1'b1, ADDR_MODE, v);
      repeat (2) @(posedge sys_clk);
      check("tx_code", 32'(tx_code), i);
      check("rx_code", 32'(rx_code), 3 - i);
      check("is_e1", is_e1, !v[0]);
      check("is_j1", is_j1, v[0] & v[1]);
      bus(1'b0, ADDR_STATUS, 32'h0);
      check("status", q, 32'({v[0] & v[1], v[0] & !v[1], 1'b0}) |
            32'(!v[0]) << BIT_E1);
    end
    bus(1'b1, ADDR_MODE, RST_MODE);
    bus(1'b1, ADDR_PCD, 32'h0a);
    bus(1'b1, ADDR_PCR, 32'h15);
    bus(1'b1, ADDR_IRQ_MASK, 32'h1 << IRQ_SET);
    bus(1'b1, ADDR_OPT, 32'h1 << BIT_XIRQ);
    line(1, 1, 1);
    line(0, 1, 170);
    line(1, 1, 1);
    line(0, 1, 175);
    check("los", los, los_m);
    line(0, 1, 1);
    check("los", los, los_m);
    check("irq", irq, 32'h1);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    check("irq_stat", q, 32'h1);
    bus(1'b1, ADDR_IRQ_STAT, 32'h1);
    check("irq", irq, 32'h0);
    src.div = 14;
    line(21, 176, 352);
    src.div = 8;
    check("los", los, 32'h1);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    check("irq_stat", q & 32'h4, 32'h4);
    check("irq", irq, 32'h0);
    bus(1'b1, ADDR_OPT, 32'h3);
    line(0, 1, 16);
    line(22, 176, 160);
    check("los", los, 32'h1);
    bus(1'b1, ADDR_OPT, 32'h1);
    line(22, 176, 352);
    los_m = 1'b0;
    check("los", los, los_m);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    check("irq_stat", q, 32'h6);
    bus(1'b1, ADDR_IRQ_MASK, 32'h2);
    check("irq", irq, 32'h1);
    bus(1'b1, ADDR_IRQ_STAT, 32'h7);
    check("irq", irq, 32'h0);
    line(0, 1, 176);
    check("los", los, los_m);
    bus(1'b1, ADDR_OPT, 32'h1 << BIT_PDEN);
    line(1, 8, 352);
    los_m = 1'b0;
    check("los", los, los_m);
    line(0, 1, 176);
    check("los", los, los_m);
    bus(1'b1, ADDR_CMD, 32'h1);
    los_m = 1'b0;
    check("los", los, los_m);
    print_verdict();
  end
endmodule : tb_t1_init_los
